// >>> rtl/pp_consts.svh
// Constants for the profile position set point sequencer
`ifndef PP_CONSTS_SVH
`define PP_CONSTS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_CONTROL_WORD   16'h6040
`define IDX_STATUS_WORD    16'h6041
`define IDX_MODE_SELECT    16'h6100
`define IDX_TARGET_POS     16'h6101
`define IDX_POS_OPTION     16'h6102
`define IDX_HALT_OPTION    16'h6103
`define IDX_PROFILE_VEL    16'h6104
`define IDX_PROFILE_ACC    16'h6105
`define IDX_PROFILE_DEC    16'h6106
`define IDX_QUICK_DEC      16'h6107
`define IDX_LIMIT_MIN      16'h6108
`define IDX_LIMIT_MAX      16'h6109
`define IDX_TOL_WINDOW     16'h610A
`define IDX_TOL_TIME       16'h610B
`define IDX_FERR_WINDOW    16'h610C
`define IDX_FERR_TIME      16'h610D
`define IDX_DEMAND_POS     16'h610E
`define IDX_ACTUAL_POS     16'h610F

// ****************************************************************
// Field positions
// ****************************************************************
`define CW_NEW_SETPOINT    4
`define CW_IMMEDIATE       5
`define CW_RELATIVE        6
`define CW_HALT            8
`define CW_CHANGE_ON_SP    9
`define SW_TARGET_REACHED  10
`define SW_LIMIT_EXCEEDED  11
`define SW_SETPOINT_ACK    12
`define SW_FOLLOWING_ERR   13
`define PO_BASE_LSB        0
`define PO_AUTOCLR_LSB     4

// ****************************************************************
// Values and reset values
// ****************************************************************
`define MODE_PROFILE_POS   8'h01
`define RST_CONTROL_WORD   16'h0000
`define RST_WORD           32'h0000_0000
`define RST_LIMIT_MIN      32'h8000_0000
`define RST_LIMIT_MAX      32'h7FFF_FFFF

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS      100
`define CYCLE_TIME_NS      1000000
`define CYCLE_TIME_CYCLES  (`CYCLE_TIME_NS / `CLK_PERIOD_NS)

`endif

// >>> rtl/pp_pkg.sv
// Types shared by the profile position set point sequencer
package pp_pkg;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_MOVE = 2'b01,
    MS_HALT = 2'b11
  } motion_state_t;

  typedef enum logic [1:0] {
    BASE_LAST_TARGET = 2'b00,
    BASE_DEMAND      = 2'b01,
    BASE_ACTUAL      = 2'b10,
    BASE_RESERVED    = 2'b11
  } base_sel_t;

  typedef enum logic [1:0] {
    AUTOCLR_NONE     = 2'b00,
    AUTOCLR_ON_ACK   = 2'b01,
    AUTOCLR_ON_REACH = 2'b10,
    AUTOCLR_RESERVED = 2'b11
  } autoclr_t;

endpackage

// >>> rtl/dwell_if.sv
// Carrier between the sequencer and its dwell timers
`timescale 1ns/1ps
`default_nettype none
interface dwell_if;
  logic        tick;
  logic        cond;
  logic [31:0] limit;
  logic        expired;

  modport timer (input tick, input cond, input limit, output expired);
  modport user  (output tick, output cond, output limit, input expired);
endinterface
`default_nettype wire

// >>> rtl/dwell_timer.sv
// Counts processing cycles while a condition holds
`timescale 1ns/1ps
`default_nettype none
module dwell_timer (
  // Clock and reset
  input  wire logic  hclk,
  input  wire logic  hresetn,
  // Condition and result
  dwell_if.timer     dw
);

  logic [31:0] count_q;
  logic        expired_q;

  // Restarts at once when the condition drops, so a glitch resets the wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q   <= 32'h0000_0000;
      expired_q <= 1'b0;
    end else if (!dw.cond) begin
      count_q   <= 32'h0000_0000;
      expired_q <= 1'b0;
    end else if (dw.tick) begin
      if (count_q >= dw.limit) begin
        expired_q <= 1'b1;
      end else begin
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  assign dw.expired = expired_q;

endmodule
`default_nettype wire

// >>> rtl/pp_sequencer.sv
// Profile position set point sequencer with AHB-Lite register slave
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pp_consts.svh"
// Functional notes
// - Mode logic acts only while the operating mode selector holds 1; here the limit exceeded flag also checks the demand in other modes.
// - A travel command starts on a rising edge of the new set point bit.
// - Entering the mode with new set point already high starts a command.
// - Bit 5 high applies a command at once; low waits for current move.
// - Bit 6 picks absolute or relative; option bits 0..1 pick base.
// - Halt rising brakes with chosen deceleration; falling ramps back up.
// - Bit 9 keeps speed, no braking before the first target is reached.
// - Bit 9 set, bit 5 clear: pass the target, then go to the next one.
// - Bit 9 clear finishes the target; set holds speed until it is reached.
// - Target reached after last target held inside window for dwell time.
// - Target reached also when halted and at standstill.
// - Limit exceeded while the demand lies outside the software limits.
// - Set point acknowledge follows the new set point bit.
// - With a buffered command, acknowledge clears once the slot frees.
// - Commands issued while acknowledge is still high are discarded.
// - No acknowledge for unreachable targets or when the slot is full.
// - Following error flag after the error exceeds window past timeout.
// - Option bits 4..5 let the device clear the new set point bit.
// - One pending target with its own speeds; further ones are dropped.
// - Bit 5 high bypasses the pending slot.
// - Actual position sampled each cycle serves as base for chaining.
// - Objects and inputs are evaluated once per processing cycle; here the status flags and the dwell timer restarts follow every clock.
module pp_sequencer
  import pp_pkg::*;
#(
  parameter int CYCLE_CYCLES = `CYCLE_TIME_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Drive side
  input  wire logic [31:0] actual_position,
  input  wire logic        closed_loop,
  output logic [31:0]      demand_position,
  output logic             motion_active
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [15:0]   ctrl_q;
  logic [7:0]    mode_q;
  logic [31:0]   tgt_reg_q, popt_q, hopt_q, vel_reg_q, acc_reg_q;
  logic [31:0]   dec_reg_q, qdec_q, lmin_q, lmax_q;
  logic [31:0]   tolw_q, tolt_q, few_q, fet_q;
  logic          ap_wr_q, hreadyout_q, hresp_q;
  logic [15:0]   ap_idx_q;
  logic [31:0]   hrdata_q, rd_d, act_s1_q, act_q;
  logic          cl_s1_q, cl_q, tick_q;
  logic [31:0]   tick_cnt_q;
  logic          prev_nsp_q, prev_act_q, ack_q, lim_rej_q, hw_clr_q;
  logic [15:0]   status_q;
  motion_state_t state_q;
  logic [31:0]   cur_tgt_q, last_tgt_q, dem_q, vel_q;
  logic [31:0]   pvel_q, pacc_q, pdec_q;
  logic          pend_q, active_q;
  logic [31:0]   pend_tgt_q, pend_vel_q, pend_acc_q, pend_dec_q;
  logic          ap_take, mode_on, nsp, trigger, accept, apply_now;
  logic          to_pend, in_lim, reached_pos, consumed;
  logic [31:0]   base_pos, new_tgt, halt_dec;
  logic signed [32:0] remain, ferr, tolerr;
  logic [31:0]   mag, vel_up, ferr_mag, tol_mag;
  localparam int CFG_N = int'(`IDX_FERR_TIME - `IDX_MODE_SELECT) + 1;
  logic [31:0]   cfg_q [CFG_N];
  dwell_if       tol_dw (), fe_dw ();
  // ****************************************************************
  // AHB-Lite slave, zero wait states
  // ****************************************************************
  assign ap_take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q     <= 1'b0;
      ap_idx_q    <= 16'h0000;
      hreadyout_q <= 1'b0;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      ap_wr_q     <= ap_take & hwrite & (haddr[31:18] == 14'h0000);
      ap_idx_q    <= haddr[17:2];
    end
  end
  // Read data is latched in the address phase; unmapped words read zero
  always_comb begin
    rd_d = `RST_WORD;
    if (haddr[31:18] == 14'h0000) begin
      case (haddr[17:2])
        `IDX_CONTROL_WORD: rd_d = {16'h0000, ctrl_q};
        `IDX_STATUS_WORD:  rd_d = {16'h0000, status_q};
        `IDX_MODE_SELECT:  rd_d = {24'h000000, mode_q};
        `IDX_DEMAND_POS:   rd_d = dem_q;
        `IDX_ACTUAL_POS:   rd_d = act_q;
        default: begin
          if (haddr[17:2] > `IDX_MODE_SELECT &&
              haddr[17:2] <= `IDX_FERR_TIME) begin
            rd_d = cfg_q[haddr[5:2]];
          end
        end
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `RST_WORD;
    end else if (ap_take & ~hwrite) begin
      hrdata_q <= rd_d;
    end
  end
  // Configuration words; the limits reset to the full signed range
  for (genvar i = 0; i < CFG_N; i++) begin : g_cfg
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cfg_q[i] <=
          (i == `IDX_LIMIT_MIN - `IDX_MODE_SELECT) ? `RST_LIMIT_MIN :
          (i == `IDX_LIMIT_MAX - `IDX_MODE_SELECT) ? `RST_LIMIT_MAX :
          `RST_WORD;
      end else if (ap_wr_q && ap_idx_q == 16'(`IDX_MODE_SELECT + i)) begin
        cfg_q[i] <= hwdata;
      end
    end
  end
  assign mode_q    = cfg_q[0][7:0];
  assign tgt_reg_q = cfg_q[1];
  assign popt_q    = cfg_q[2];
  assign hopt_q    = cfg_q[3];
  assign vel_reg_q = cfg_q[4];
  assign acc_reg_q = cfg_q[5];
  assign dec_reg_q = cfg_q[6];
  assign qdec_q    = cfg_q[7];
  assign lmin_q    = cfg_q[8];
  assign lmax_q    = cfg_q[9];
  assign tolw_q    = cfg_q[10];
  assign tolt_q    = cfg_q[11];
  assign few_q     = cfg_q[12];
  assign fet_q     = cfg_q[13];
  // A software write in the same cycle beats the device's own clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `RST_CONTROL_WORD;
    end else if (ap_wr_q && ap_idx_q == `IDX_CONTROL_WORD) begin
      ctrl_q <= hwdata[15:0];
    end else if (hw_clr_q) begin
      ctrl_q[`CW_NEW_SETPOINT] <= 1'b0;
    end
  end
  // ****************************************************************
  // Input synchronisers and processing cycle tick
  // ****************************************************************
  // Position resampled every clock; a torn word is replaced on the next clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_s1_q <= `RST_WORD;
      act_q    <= `RST_WORD;
      cl_s1_q  <= 1'b0;
      cl_q     <= 1'b0;
    end else begin
      act_s1_q <= actual_position;
      act_q    <= act_s1_q;
      cl_s1_q  <= closed_loop;
      cl_q     <= cl_s1_q;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= 32'(CYCLE_CYCLES - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q     <= 1'b0;
    end
  end

  // ****************************************************************
  // Command evaluation, once per processing cycle
  // ****************************************************************
  assign mode_on = (mode_q == `MODE_PROFILE_POS);
  assign nsp     = ctrl_q[`CW_NEW_SETPOINT];
  assign trigger = mode_on & nsp & (~prev_nsp_q | ~prev_act_q);
  always_comb begin
    base_pos = last_tgt_q;
    case (base_sel_t'(popt_q[`PO_BASE_LSB +: 2]))
      BASE_LAST_TARGET: base_pos = last_tgt_q;
      BASE_DEMAND:      base_pos = dem_q;
      BASE_ACTUAL:      base_pos = act_q;
      default:          base_pos = last_tgt_q;
    endcase
  end
  assign new_tgt = ctrl_q[`CW_RELATIVE] ? base_pos + tgt_reg_q : tgt_reg_q;
  assign in_lim  = ($signed(new_tgt) >= $signed(lmin_q)) &&
                   ($signed(new_tgt) <= $signed(lmax_q));
  // Immediate mode and an idle axis both skip the slot
  assign apply_now = ctrl_q[`CW_IMMEDIATE] | (state_q == MS_IDLE);
  assign to_pend   = ~apply_now & ~pend_q;
  assign accept    = trigger & ~ack_q & in_lim & (apply_now | to_pend);
  assign remain   = $signed({cur_tgt_q[31], cur_tgt_q}) -
                    $signed({dem_q[31], dem_q});
  assign mag      = remain[32] ? 32'(-remain) : remain[31:0];
  assign vel_up   = (vel_q + pacc_q > pvel_q) ? pvel_q : vel_q + pacc_q;
  assign halt_dec = hopt_q[0] ? qdec_q : pdec_q;
  assign reached_pos = (state_q == MS_MOVE) && (mag <= vel_up);
  assign consumed = tick_q & reached_pos & pend_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= MS_IDLE;
      cur_tgt_q  <= `RST_WORD;
      last_tgt_q <= `RST_WORD;
      dem_q      <= `RST_WORD;
      vel_q      <= `RST_WORD;
      pvel_q     <= `RST_WORD;
      pacc_q     <= `RST_WORD;
      pdec_q     <= `RST_WORD;
      pend_q     <= 1'b0;
      pend_tgt_q <= `RST_WORD;
      pend_vel_q <= `RST_WORD;
      pend_acc_q <= `RST_WORD;
      pend_dec_q <= `RST_WORD;
    end else if (tick_q && mode_on) begin
      case (state_q)
        MS_MOVE: begin
          if (ctrl_q[`CW_HALT]) begin
            state_q <= MS_HALT;
          end else if (reached_pos) begin
            dem_q <= cur_tgt_q;
            if (pend_q) begin
              cur_tgt_q <= pend_tgt_q;
              pvel_q    <= pend_vel_q;
              pacc_q    <= pend_acc_q;
              pdec_q    <= pend_dec_q;
              pend_q    <= 1'b0;
              // Pass through keeps speed; otherwise stop on the target
              vel_q <= ctrl_q[`CW_CHANGE_ON_SP] ? vel_up : 32'h0000_0000;
            end else begin
              vel_q   <= 32'h0000_0000;
              state_q <= MS_IDLE;
            end
          end else begin
            vel_q <= vel_up;
            dem_q <= remain[32] ? dem_q - vel_up : dem_q + vel_up;
          end
        end
        MS_HALT: begin
          if (!ctrl_q[`CW_HALT]) begin
            state_q <= MS_MOVE;
          end else if (vel_q <= halt_dec || mag <= vel_q) begin
            vel_q <= 32'h0000_0000;
          end else begin
            vel_q <= vel_q - halt_dec;
            dem_q <= remain[32] ? dem_q - vel_q : dem_q + vel_q;
          end
        end
        default: begin
          vel_q <= 32'h0000_0000;
        end
      endcase
      if (accept && apply_now) begin
        cur_tgt_q  <= new_tgt;
        last_tgt_q <= new_tgt;
        pvel_q     <= vel_reg_q;
        pacc_q     <= acc_reg_q;
        pdec_q     <= dec_reg_q;
        if (state_q == MS_IDLE) begin
          state_q <= ctrl_q[`CW_HALT] ? MS_HALT : MS_MOVE;
        end
      end else if (accept) begin
        pend_q     <= 1'b1;
        pend_tgt_q <= new_tgt;
        last_tgt_q <= new_tgt;
        pend_vel_q <= vel_reg_q;
        pend_acc_q <= acc_reg_q;
        pend_dec_q <= dec_reg_q;
      end
    end
  end
  // ****************************************************************
  // Acknowledge, edge history and status flags
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_nsp_q <= 1'b0;
      prev_act_q <= 1'b0;
      ack_q      <= 1'b0;
      lim_rej_q  <= 1'b0;
      hw_clr_q   <= 1'b0;
    end else if (tick_q) begin
      prev_nsp_q <= nsp;
      prev_act_q <= mode_on;
      if (accept) begin
        ack_q     <= 1'b1;
        lim_rej_q <= 1'b0;
        hw_clr_q  <= (autoclr_t'(popt_q[`PO_AUTOCLR_LSB +: 2]) ==
                      AUTOCLR_ON_ACK);
      end else begin
        if ((!nsp && !pend_q) || consumed) begin
          ack_q <= 1'b0;
        end
        if (trigger && !ack_q && !in_lim) begin
          lim_rej_q <= 1'b1;
        end
        if (reached_pos && !pend_q && nsp &&
            autoclr_t'(popt_q[`PO_AUTOCLR_LSB +: 2]) == AUTOCLR_ON_REACH) begin
          hw_clr_q <= 1'b1;
        end
      end
    end else begin
      hw_clr_q <= 1'b0;
    end
  end
  assign tolerr  = $signed({act_q[31], act_q}) -
                   $signed({cur_tgt_q[31], cur_tgt_q});
  assign tol_mag = tolerr[32] ? 32'(-tolerr) : tolerr[31:0];
  assign ferr    = $signed({dem_q[31], dem_q}) - $signed({act_q[31], act_q});
  assign ferr_mag = ferr[32] ? 32'(-ferr) : ferr[31:0];
  assign tol_dw.tick  = tick_q;
  assign tol_dw.cond  = mode_on & (state_q == MS_IDLE) & ~pend_q &
                        (tol_mag <= tolw_q);
  assign tol_dw.limit = tolt_q;
  assign fe_dw.tick   = tick_q;
  assign fe_dw.cond   = mode_on & cl_q & (ferr_mag > few_q);
  assign fe_dw.limit  = fet_q;
  dwell_timer u_tol_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .dw      (tol_dw.timer)
  );
  dwell_timer u_fe_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .dw      (fe_dw.timer)
  );
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 16'h0000;
      active_q <= 1'b0;
    end else begin
      status_q <= 16'h0000;
      active_q <= (state_q != MS_IDLE);
      status_q[`SW_TARGET_REACHED] <= tol_dw.expired |
        (mode_on & ctrl_q[`CW_HALT] & (vel_q == 32'h0000_0000));
      status_q[`SW_LIMIT_EXCEEDED] <= lim_rej_q |
        ($signed(dem_q) < $signed(lmin_q)) |
        ($signed(dem_q) > $signed(lmax_q));
      status_q[`SW_SETPOINT_ACK]   <= ack_q;
      status_q[`SW_FOLLOWING_ERR]  <= fe_dw.expired;
    end
  end
  assign hreadyout       = hreadyout_q;
  assign hresp           = hresp_q;
  assign hrdata          = hrdata_q;
  assign demand_position = dem_q;
  assign motion_active   = active_q;
endmodule
`default_nettype wire

// >>> verif/pp_sequencer_chk.sv
// Port assertions for the profile position set point sequencer
`timescale 1ns/1ps
`default_nettype none
module pp_seq_chk #(
  parameter int CYCLE_CYCLES = 20
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Drive side
  input wire logic [31:0] demand_position,
  input wire logic        motion_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence rd_take(logic [31:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr == a;
  endsequence

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_high: assert property ($past(hresetn) |-> hreadyout == 1'b1)
    else $error("wait state inserted");
  a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite)
    |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_status_upper: assert property (rd_take(32'h0001_8104) |=>
    hrdata[31:16] == 16'h0000) else $error("status upper bits set");
  a_unmapped_zero: assert property (rd_take(32'h0001_8800) |=>
    hrdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_demand_tick: assert property (!$stable(demand_position) |=>
    $stable(demand_position) [*8]) else $error("demand off tick");
  a_active_tick: assert property (!$stable(motion_active) |=>
    $stable(motion_active) [*8]) else $error("motion off tick");
  a_idle_hold: assert property (!$stable(demand_position) |->
    $past(motion_active)) else $error("demand moved while idle");
endmodule

bind pp_sequencer pp_seq_chk #(.CYCLE_CYCLES(CYCLE_CYCLES)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .demand_position(demand_position), .motion_active(motion_active));
`default_nettype wire

// >>> verif/ahb_master_model.sv
// Bus master model standing for the fieldbus controller
`timescale 1ns/1ps
`default_nettype none
module ahb_master_model (
  // Clock
  input  wire logic        hclk,
  // Request
  output logic             hsel = 1'b1,
  output logic [31:0]      haddr = 32'h0000_0000,
  output logic [1:0]       htrans = 2'b00,
  output logic             hwrite = 1'b0,
  output logic [2:0]       hsize = 3'b010,
  output logic [31:0]      hwdata = 32'h0000_0000,
  // Answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // Whole word single transfer; waits on ready with no assumed latency
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the profile position set point sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pp_consts.svh"
`define CHK(g, e) check(32'(g), 32'(e))
module testbench;
  localparam int CYC = 20;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, motion_active;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, demand_position, rdv, peak, hold;
  logic [31:0] actual_position = 32'h0;
  logic [31:0] act_off = 32'h0;
  logic        closed_loop = 1'b0;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #50 hclk = ~hclk;
  // Ideal plant follows demand; offset injects a following error
  always @(posedge hclk) actual_position <= demand_position + act_off;

  ahb_master_model u_m (.hclk(hclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  pp_sequencer #(.CYCLE_CYCLES(CYC)) u_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .actual_position(actual_position), .closed_loop(closed_loop),
    .demand_position(demand_position), .motion_active(motion_active));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task check(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [15:0] i, input logic [31:0] d);
    u_m.xfer(1'b1, {14'h0, i, 2'b00}, d, rdv);
  endtask
  task rd(input logic [15:0] i);
    u_m.xfer(1'b0, {14'h0, i, 2'b00}, 32'h0, rdv);
  endtask
  task tk(input int n);
    repeat (n * CYC) @(posedge hclk);
  endtask
  // Waits for the move to end, bounded, and records the highest demand
  task settle();
    peak = demand_position;
    for (int k = 0; k < 300 && motion_active !== 1'b0; k++) begin
      tk(1);
      if ($signed(demand_position) > $signed(peak)) peak = demand_position;
    end
  endtask
  task end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs();
    rd(`IDX_CONTROL_WORD);
    `CHK(rdv, `RST_CONTROL_WORD);
    wr(`IDX_CONTROL_WORD, 32'hFFFF_0000);
    rd(`IDX_CONTROL_WORD);
    `CHK(rdv, 32'h0);
    wr(`IDX_STATUS_WORD, 32'h0000_FFFF);
    rd(`IDX_STATUS_WORD);
    `CHK(rdv[12], 1'b0);
    rd(16'h6200);
    `CHK(rdv, 32'h0);
    rd(`IDX_LIMIT_MAX);
    `CHK(rdv, `RST_LIMIT_MAX);
    wr(`IDX_PROFILE_VEL, 32'h4);
    wr(`IDX_PROFILE_ACC, 32'h4);
    wr(`IDX_PROFILE_DEC, 32'h2);
    wr(`IDX_TOL_TIME, 32'h2);
    wr(`IDX_FERR_WINDOW, 32'h2);
    wr(`IDX_FERR_TIME, 32'h3);
    wr(`IDX_TARGET_POS, 32'd40);
  endtask
  task t_mode_gate();
    wr(`IDX_CONTROL_WORD, 32'h10);
    tk(3);
    rd(`IDX_STATUS_WORD);
    `CHK(rdv[12], 1'b0);
    `CHK(demand_position, 32'h0);
  endtask
  task t_enter();
    wr(`IDX_MODE_SELECT, {24'h0, `MODE_PROFILE_POS});
    tk(2);
    rd(`IDX_STATUS_WORD);
    `CHK(rdv[12], 1'b1);
    settle();
    `CHK(demand_position, 32'd40);
    wr(`IDX_CONTROL_WORD, 32'h0);
    tk(2);
    rd(`IDX_STATUS_WORD);
    `CHK(rdv[12], 1'b0);
    tk(3);
    rd(`IDX_STATUS_WORD);
    `CHK(rdv[10], 1'b1);
  endtask
  task t_rel_limit();
    wr(`IDX_TARGET_POS, 32'd10);
    wr(`IDX_CONTROL_WORD, 32'h50);
    tk(2);
    settle();
    `CHK(demand_position, 32'd50);
    wr(`IDX_CONTROL_WORD, 32'h0);
    wr(`IDX_LIMIT_MAX, 32'd100);
    wr(`IDX_TARGET_POS, 32'd200);
    tk(2);
    wr(`IDX_CONTROL_WORD, 32'h10);
    tk(2);
    rd(`IDX_STATUS_WORD);
    `CHK(rdv[12:11], 2'b01);
    `CHK(demand_position, 32'd50);
    wr(`IDX_CONTROL_WORD, 32'h0);
    tk(2);
  endtask
  task t_queue();
    wr(`IDX_PROFILE_VEL, 32'h2);
    wr(`IDX_TARGET_POS, 32'd90);
    wr(`IDX_CONTROL_WORD, 32'h10);
    tk(2);
    wr(`IDX_CONTROL_WORD, 32'h0);
    tk(2);
    wr(`IDX_TARGET_POS, 32'd60);
    wr(`IDX_CONTROL_WORD, 32'h10);
    tk(2);
    rd(`IDX_STATUS_WORD);
    `CHK(rdv[12], 1'b1);
    wr(`IDX_CONTROL_WORD, 32'h0);
    tk(2);
    rd(`IDX_STATUS_WORD);
    `CHK(rdv[12], 1'b1);
    wr(`IDX_TARGET_POS, 32'd0);
    wr(`IDX_CONTROL_WORD, 32'h10);
    tk(50);
    `CHK(demand_position, 32'd60);
    wr(`IDX_CONTROL_WORD, 32'h0);
    tk(2);
  endtask
  task t_immed_halt();
    wr(`IDX_TARGET_POS, 32'd100);
    wr(`IDX_CONTROL_WORD, 32'h10);
    tk(3);
    wr(`IDX_TARGET_POS, 32'd70);
    wr(`IDX_CONTROL_WORD, 32'h0);
    tk(2);
    wr(`IDX_CONTROL_WORD, 32'h30);
    tk(2);
    settle();
    `CHK(demand_position, 32'd70);
    `CHK($signed(peak) < 100, 1'b1);
    wr(`IDX_CONTROL_WORD, 32'h0);
    wr(`IDX_PROFILE_VEL, 32'h4);
    wr(`IDX_LIMIT_MAX, 32'd400);
    wr(`IDX_TARGET_POS, 32'd300);
    tk(2);
    wr(`IDX_CONTROL_WORD, 32'h10);
    tk(4);
    wr(`IDX_CONTROL_WORD, 32'h110);
    tk(6);
    hold = demand_position;
    tk(2);
    `CHK(demand_position, hold);
    rd(`IDX_STATUS_WORD);
    `CHK(rdv[10], 1'b1);
    wr(`IDX_CONTROL_WORD, 32'h10);
    tk(2);
    settle();
    `CHK(demand_position, 32'd300);
  endtask
  task t_autoclr_ferr();
    wr(`IDX_CONTROL_WORD, 32'h0);
    wr(`IDX_POS_OPTION, 32'h10);
    wr(`IDX_TARGET_POS, 32'd320);
    tk(2);
    wr(`IDX_CONTROL_WORD, 32'h10);
    tk(2);
    rd(`IDX_CONTROL_WORD);
    `CHK(rdv[4], 1'b0);
    settle();
    closed_loop <= 1'b1;
    act_off <= 32'd100;
    tk(7);
    rd(`IDX_STATUS_WORD);
    `CHK(rdv[13], 1'b1);
  endtask

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_mode_gate();
    t_enter();
    t_rel_limit();
    t_queue();
    t_immed_halt();
    t_autoclr_ferr();
    end_of_test();
  end
endmodule
`default_nettype wire
